// *** src/tfc_feature_ctrl.sv ***
// Test and feature control register with APB access and tx poll logic
`timescale 1ns/100ps
`include "tfc_consts.svh"

module tfc_feature_ctrl
  import tfc_pkg::*;
#(
  parameter int POLL_CYC = `TFC_POLL_CYC
) (
  input wire logic pclk, // APB clock
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic transmitter_on, // Tx engine running
  input wire logic missed_ctr_wrap, // Missed counter wrapped
  input wire logic rx_coll_ctr_wrap, // Collision counter wrapped
  input wire logic tx_frame_begin, // Tx frame started
  input wire logic rx_activity_done, // Receive activity ended
  input wire logic tx_check_seq_disable, // Global fcs disable
  input wire logic desc_add_check_seq, // Descriptor adds fcs
  input wire logic [10:0] tx_frame_len, // Tx bytes without fcs
  output logic tx_poll_req, // One-cycle poll request
  output logic [7:0] tx_pad_bytes, // Pad bytes to append
  output logic tx_append_fcs, // Append fcs after pad
  output logic rx_strip_pad_fcs, // Receiver strips pad, fcs
  output logic soft_reset_pulse, // Soft reset to others
  output logic stop_pulse, // Stop command to others
  output logic irq // Interrupt request
);

  // Parameter sanity
  // The interval timer is 16 bits wide and must count at least once
  generate
    if (POLL_CYC < 2 || POLL_CYC > 65535) begin : g_bad
      $error("POLL_CYC out of range");
    end
  endgenerate

  // Register bits
  logic legacy_bit;
  logic tx_poll_disable;
  logic tx_auto_pad_en;
  logic rx_auto_strip_en;
  logic missed_ctr_ovf_flag;
  logic missed_ctr_ovf_mask;
  logic user_irq_command;
  logic user_irq_flag;
  logic rx_coll_ctr_ovf_flag;
  logic rx_coll_ctr_ovf_mask;
  logic tx_start_flag;
  logic tx_start_mask;
  logic global_irq_enable;
  logic tx_demand;
  logic combined_irq_flag;
  logic [15:0] poll_cnt;
  logic poll_due;
  logic rx_poll_pend; // Receive poll waiting to be served
  logic poll_reason; // Any reason to poll this cycle

  // Bus decode
  tfc_sel_t sel;
  logic setup;
  logic wr;
  logic wr_feat;
  logic wr_ctrl;
  logic [31:0] rd_val;
  logic soft_rst;
  logic stop_cmd;
  logic [7:0] short_gap;
  logic is_short;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;

  // One-hot select from address
  // Only the three word offsets decode; anything else reads zero
  always_comb begin
    case (paddr)
      `TFC_OFF_FEAT: sel = TFC_SEL_FEAT;
      `TFC_OFF_CTRL: sel = TFC_SEL_CTRL;
      `TFC_OFF_STAT: sel = TFC_SEL_STAT;
      default: sel = TFC_SEL_NONE;
    endcase
  end

  assign wr_feat = wr & (sel == TFC_SEL_FEAT);
  assign wr_ctrl = wr & (sel == TFC_SEL_CTRL);

  // Zero wait states; unmapped address errors
  assign pready = 1'b1;
  assign pslverr = psel & penable & (sel == TFC_SEL_NONE);

  // Commands written as one-shot ones
  assign soft_rst = wr_ctrl & pwdata[`TFC_B_SRESET];
  assign stop_cmd = wr_ctrl & pwdata[`TFC_B_STOP];

  // Forward commands to the rest of the controller
  // Registered so the others see a clean one-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_pulse <= 1'b0;
      stop_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= soft_rst;
      stop_pulse <= stop_cmd;
    end
  end

  // Enables and legacy bit: stop leaves them alone
  // A write updates every feature bit at once; there are no byte lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      legacy_bit <= 1'b0;
      tx_poll_disable <= 1'b0;
      tx_auto_pad_en <= 1'b0;
      rx_auto_strip_en <= 1'b0;
    end else if (soft_rst) begin
      legacy_bit <= 1'b0;
      tx_poll_disable <= 1'b0;
      tx_auto_pad_en <= 1'b0;
      rx_auto_strip_en <= 1'b0;
    end else if (wr_feat) begin
      legacy_bit <= pwdata[`TFC_B_LEGACY];
      tx_poll_disable <= pwdata[`TFC_B_POLLDIS];
      tx_auto_pad_en <= pwdata[`TFC_B_APAD];
      rx_auto_strip_en <= pwdata[`TFC_B_ASTRIP];
    end
  end

  // Masks come up set so nothing interrupts before software is ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      missed_ctr_ovf_mask <= 1'b1;
      rx_coll_ctr_ovf_mask <= 1'b1;
      tx_start_mask <= 1'b1;
    end else if (soft_rst) begin
      missed_ctr_ovf_mask <= 1'b1;
      rx_coll_ctr_ovf_mask <= 1'b1;
      tx_start_mask <= 1'b1;
    end else if (wr_feat) begin
      missed_ctr_ovf_mask <= pwdata[`TFC_B_MISS_MASK];
      rx_coll_ctr_ovf_mask <= pwdata[`TFC_B_RCCOM];
      tx_start_mask <= pwdata[`TFC_B_TXSM];
    end
  end

  // Event flags: a write of one clears, a new event wins
  // Stop and soft reset beat a same-cycle event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      missed_ctr_ovf_flag <= 1'b0;
      rx_coll_ctr_ovf_flag <= 1'b0;
      tx_start_flag <= 1'b0;
    end else if (soft_rst || stop_cmd) begin
      missed_ctr_ovf_flag <= 1'b0;
      rx_coll_ctr_ovf_flag <= 1'b0;
      tx_start_flag <= 1'b0;
    end else begin
      missed_ctr_ovf_flag <= missed_ctr_wrap |
        (missed_ctr_ovf_flag & ~(wr_feat & pwdata[`TFC_B_MISS_OVF]));
      rx_coll_ctr_ovf_flag <= rx_coll_ctr_wrap |
        (rx_coll_ctr_ovf_flag & ~(wr_feat & pwdata[`TFC_B_RCCO]));
      tx_start_flag <= tx_frame_begin |
        (tx_start_flag & ~(wr_feat & pwdata[`TFC_B_TXS]));
    end
  end

  // User interrupt command and flag
  // Clearing the flag also drops the command, else it would re-set at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_irq_command <= 1'b0;
      user_irq_flag <= 1'b0;
    end else if (soft_rst || stop_cmd) begin
      user_irq_command <= 1'b0;
      user_irq_flag <= 1'b0;
    end else if (wr_feat && pwdata[`TFC_B_UFLAG]) begin
      user_irq_command <= 1'b0;
      user_irq_flag <= 1'b0;
    end else begin
      if (wr_feat && pwdata[`TFC_B_UCMD]) begin
        user_irq_command <= 1'b1;
      end
      user_irq_flag <= user_irq_flag | user_irq_command;
    end
  end

  // Global interrupt enable; stop and soft reset both drop it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable <= 1'b0;
    end else if (soft_rst || stop_cmd) begin
      global_irq_enable <= 1'b0;
    end else if (wr_ctrl) begin
      global_irq_enable <= pwdata[`TFC_B_IRQ_EN];
    end
  end

  // Demand is held until a poll serves it; a new demand wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_demand <= 1'b0;
    end else if (soft_rst || stop_cmd) begin
      tx_demand <= 1'b0;
    end else if (wr_ctrl && pwdata[`TFC_B_DEMAND]) begin
      tx_demand <= 1'b1;
    end else if (tx_poll_req) begin
      tx_demand <= 1'b0;
    end
  end

  // Combined flag from every unmasked source
  // Command and flag both count, so the request stands from the write on
  always_comb begin
    combined_irq_flag = (missed_ctr_ovf_flag & ~missed_ctr_ovf_mask) |
      (rx_coll_ctr_ovf_flag & ~rx_coll_ctr_ovf_mask) |
      (tx_start_flag & ~tx_start_mask) |
      user_irq_command |
      user_irq_flag;
  end

  // Interrupt output is registered, one cycle behind the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= combined_irq_flag & global_irq_enable;
    end
  end

  // Automatic poll interval timer; only runs with the transmitter on
  // Any poll restarts it, so timer and demand polls never stack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_cnt <= 16'h0000;
    end else if (!transmitter_on || tx_poll_disable || tx_poll_req) begin
      poll_cnt <= 16'h0000;
    end else if (!poll_due) begin
      poll_cnt <= poll_cnt + 16'h0001;
    end
  end

  assign poll_due = (poll_cnt == 16'(POLL_CYC - 1));

  // Receive-done poll is remembered, so a pulse that meets a poll
  // in flight or a stopped transmitter is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_poll_pend <= 1'b0;
    end else if (soft_rst || stop_cmd) begin
      rx_poll_pend <= 1'b0;
    end else if (rx_activity_done) begin
      rx_poll_pend <= 1'b1;
    end else if (tx_poll_req) begin
      rx_poll_pend <= 1'b0;
    end
  end

  // Every reason for a poll; the transmitter gate is applied below
  assign poll_reason = (poll_due & ~tx_poll_disable) |
    tx_demand |
    rx_poll_pend |
    rx_activity_done;

  // Poll request pulse; nothing while the transmitter is off
  // Never two in a row: the cycle after a request is always quiet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_poll_req <= 1'b0;
    end else if (tx_poll_req || !transmitter_on) begin
      tx_poll_req <= 1'b0;
    end else begin
      tx_poll_req <= poll_reason;
    end
  end

  // Short frame check: length without fcs below 60 bytes
  // Only the low byte feeds the pad count; a short frame never exceeds it
  assign short_gap = `TFC_MIN_FRAME - `TFC_FCS_LEN;
  assign is_short = tx_frame_len < {3'b000, short_gap};

  // Padding and fcs control, registered toward the transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pad_bytes <= 8'h00;
      tx_append_fcs <= 1'b1;
    end else if (tx_auto_pad_en && is_short) begin
      tx_pad_bytes <= short_gap - tx_frame_len[7:0];
      tx_append_fcs <= 1'b1;
    end else begin
      tx_pad_bytes <= 8'h00;
      tx_append_fcs <= ~tx_check_seq_disable | desc_add_check_seq;
    end
  end

  // Strip control follows the enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_strip_pad_fcs <= 1'b0;
    end else begin
      rx_strip_pad_fcs <= rx_auto_strip_en;
    end
  end

  // Read mux; reserved bits read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (sel)
      TFC_SEL_FEAT: begin
        rd_val[`TFC_B_LEGACY] = legacy_bit;
        rd_val[`TFC_B_FIXED1] = 1'b1;
        rd_val[`TFC_B_POLLDIS] = tx_poll_disable;
        rd_val[`TFC_B_APAD] = tx_auto_pad_en;
        rd_val[`TFC_B_ASTRIP] = rx_auto_strip_en;
        rd_val[`TFC_B_MISS_OVF] = missed_ctr_ovf_flag;
        rd_val[`TFC_B_MISS_MASK] = missed_ctr_ovf_mask;
        rd_val[`TFC_B_UCMD] = user_irq_command;
        rd_val[`TFC_B_UFLAG] = user_irq_flag;
        rd_val[`TFC_B_RCCO] = rx_coll_ctr_ovf_flag;
        rd_val[`TFC_B_RCCOM] = rx_coll_ctr_ovf_mask;
        rd_val[`TFC_B_TXS] = tx_start_flag;
        rd_val[`TFC_B_TXSM] = tx_start_mask;
      end
      TFC_SEL_CTRL: begin
        rd_val[`TFC_B_IRQ_EN] = global_irq_enable;
      end
      TFC_SEL_STAT: begin
        rd_val[`TFC_B_TX_RUN] = transmitter_on;
        rd_val[`TFC_B_IRQ_ANY] = combined_irq_flag;
        rd_val[`TFC_B_DMDPEND] = tx_demand;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  // Read data captured in the setup cycle
  // A flag that sets during the access cycle shows on the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= rd_val;
    end
  end

endmodule // tfc_feature_ctrl

// *** src/tfc_consts.svh ***
// Offsets, field positions, frame sizes and poll default of the feature control block
`ifndef TFC_CONSTS_SVH
`define TFC_CONSTS_SVH

// Byte offsets of the registers
`define TFC_OFF_FEAT 12'h000
`define TFC_OFF_CTRL 12'h004
`define TFC_OFF_STAT 12'h008

// Feature/event register fields
`define TFC_B_LEGACY 15
`define TFC_B_FIXED1 14
`define TFC_B_POLLDIS 12
`define TFC_B_APAD 11
`define TFC_B_ASTRIP 10
`define TFC_B_MISS_OVF 9
`define TFC_B_MISS_MASK 8
`define TFC_B_UCMD 7
`define TFC_B_UFLAG 6
`define TFC_B_RCCO 5
`define TFC_B_RCCOM 4
`define TFC_B_TXS 3
`define TFC_B_TXSM 2

// Control register fields
`define TFC_B_IRQ_EN 0
`define TFC_B_SRESET 1
`define TFC_B_STOP 2
`define TFC_B_DEMAND 3

// Status register fields
`define TFC_B_TX_RUN 0
`define TFC_B_IRQ_ANY 1
`define TFC_B_DMDPEND 2

// Frame sizes in bytes
`define TFC_MIN_FRAME 8'h40
`define TFC_FCS_LEN 8'h04

// Default automatic poll interval in cycles
`define TFC_POLL_CYC 1600

`endif

// *** src/tfc_pkg.sv ***
// Types shared by the feature control block
package tfc_pkg;

  // One-hot register select
  typedef enum logic [3:0] {
    TFC_SEL_NONE = 4'b0001,
    TFC_SEL_FEAT = 4'b0010,
    TFC_SEL_CTRL = 4'b0100,
    TFC_SEL_STAT = 4'b1000
  } tfc_sel_t;

endpackage

// *** test/tfc_feature_ctrl_props.sv ***
// Port assertions for the feature control block
`timescale 1ns/100ps
module tfc_feature_ctrl_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pslverr, // Error
  input wire logic transmitter_on, // Tx running
  input wire logic rx_activity_done, // Rx done
  input wire logic tx_check_seq_disable, // Fcs off
  input wire logic [10:0] tx_frame_len, // Length
  input wire logic tx_poll_req, // Poll
  input wire logic [7:0] tx_pad_bytes, // Pad
  input wire logic tx_append_fcs, // Fcs on
  input wire logic soft_reset_pulse, // Soft reset
  input wire logic stop_pulse, // Stop
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase qualifier
  logic acc;
  assign acc = psel && penable;
  // Poll request timing
  a_poll_tx_off: assert property (tx_poll_req |-> $past(transmitter_on)) else $error("poll while tx off");
  a_poll_single: assert property (tx_poll_req |=> !tx_poll_req) else $error("poll pulse too long");
  a_rx_poll: assert property (rx_activity_done && transmitter_on |-> ##[1:2] tx_poll_req)
    else $error("no poll after rx");
  // Pad and check sequence
  a_pad_fcs: assert property (tx_pad_bytes != 8'h00 |-> tx_append_fcs) else $error("pad without fcs");
  a_pad_len: assert property (tx_pad_bytes != 8'h00 |-> $past(tx_frame_len) < 11'h03C &&
    tx_pad_bytes == 8'h3C - $past(tx_frame_len[7:0])) else $error("pad count wrong");
  a_fcs_on: assert property (!tx_check_seq_disable |=> tx_append_fcs) else $error("fcs dropped");
  // Register port behaviour
  a_err_map: assert property (pslverr == (acc && !(paddr inside {12'h000, 12'h004, 12'h008})))
    else $error("bad error flag");
  a_soft_pulse: assert property (acc && pwrite && paddr == 12'h004 && pwdata[1] |=> soft_reset_pulse)
    else $error("no soft reset pulse");
  a_stop_irq: assert property (stop_pulse |=> !irq) else $error("irq after stop");
  a_fixed_read: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[14] && !prdata[13] &&
    prdata[31:16] == 16'h0000 && prdata[1:0] == 2'b00) else $error("fixed bits wrong");
  // Main scenarios reached
  c_rx_poll: cover property (tx_poll_req && $past(rx_activity_done));
  c_pad: cover property (tx_pad_bytes != 8'h00);
  c_irq: cover property ($rose(irq));
endmodule // tfc_feature_ctrl_props

bind tfc_feature_ctrl tfc_feature_ctrl_props tfc_feature_ctrl_props_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .transmitter_on(transmitter_on), .rx_activity_done(rx_activity_done),
  .tx_check_seq_disable(tx_check_seq_disable), .tx_frame_len(tx_frame_len), .tx_poll_req(tx_poll_req),
  .tx_pad_bytes(tx_pad_bytes), .tx_append_fcs(tx_append_fcs), .soft_reset_pulse(soft_reset_pulse),
  .stop_pulse(stop_pulse), .irq(irq));

// *** test/tfc_feature_ctrl_test.sv ***
// Self-checking bench for the feature control block
`timescale 1ns/100ps
`include "tfc_consts.svh"
module tfc_feature_ctrl_test import tfc_pkg::*;;
  localparam logic [11:0] r_feat = `TFC_OFF_FEAT;
  localparam logic [11:0] r_ctrl = `TFC_OFF_CTRL;
  localparam logic [11:0] r_stat = `TFC_OFF_STAT;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tx_run = 0, rx_done = 0, dis = 0, add = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] evt = 0;
  logic [10:0] len = 0, v;
  wire logic [31:0] prdata;
  wire logic [7:0] pad;
  wire logic pready, pslverr, poll, fcs, strip, srp, stp, irq;
  int err_count = 0, n_checks = 0, npoll = 0, n0 = 0, seed = 78712, k;
  logic [31:0] q[$];
  logic [31:0] fl[3] = '{32'h0000_0200, 32'h0000_0020, 32'h0000_0008};

  tfc_feature_ctrl #(.POLL_CYC(8)) tfc_feature_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .transmitter_on(tx_run), .missed_ctr_wrap(evt[0]), .rx_coll_ctr_wrap(evt[1]),
    .tx_frame_begin(evt[2]), .rx_activity_done(rx_done), .tx_check_seq_disable(dis), .desc_add_check_seq(add),
    .tx_frame_len(len), .tx_poll_req(poll), .tx_pad_bytes(pad), .tx_append_fcs(fcs), .rx_strip_pad_fcs(strip),
    .soft_reset_pulse(srp), .stop_pulse(stp), .irq(irq));

  // Clock, 8 ns period
  initial forever #4 pclk = ~pclk;

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Bus cycle; bounded wait on ready so a dead slave ends the run
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    psel <= 0;
    penable <= 0;
    if (t >= 50) begin
      err_count++;
      end_of_test;
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Expected word queued; the watcher compares it when the read completes
  task rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task ev(input logic [3:0] e);
    @(posedge pclk);
    evt <= e;
    @(posedge pclk);
    evt <= 4'h0;
  endtask

  // Read watcher and poll counter
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) check(prdata, q.pop_front());
    if (psel && penable && pready === 1'b1) check(pslverr, !(paddr inside {r_feat, r_ctrl, r_stat}));
    if (poll === 1'b1) npoll <= npoll + 1;
  end

  initial begin
    cyc(12);
    presetn <= 1;
    rd(r_feat, 32'h0000_4114);
    rd(12'h00C, 32'h0000_0000);
    wr(r_feat, 32'hFFFF_FFFF);
    rd(r_feat, 32'h0000_DD14);
    wr(r_ctrl, 32'h0000_0004);
    #1 check(stp, 1);
    check(srp, 0);
    rd(r_feat, 32'h0000_DD14);
    wr(r_ctrl, 32'h0000_0002);
    #1 check(srp, 1);
    rd(r_feat, 32'h0000_4114);
    $display("register test done");
    wr(r_ctrl, 32'h0000_0001);
    for (k = 0; k < 3; k++) begin
      wr(r_feat, fl[k] >> 1);
      ev(4'(1 << k));
      cyc(1);
      rd(r_feat, 32'h0000_4000 | fl[k] | (fl[k] >> 1));
      rd(r_stat, 32'h0000_0000);
      wr(r_feat, fl[k]);
      ev(4'(1 << k));
      cyc(1);
      rd(r_stat, 32'h0000_0002);
      #1 check(irq, 1);
      wr(r_feat, fl[k]);
      rd(r_feat, 32'h0000_4000);
    end
    ev(4'h7);
    cyc(1);
    wr(r_ctrl, 32'h0000_0004);
    rd(r_feat, 32'h0000_4000);
    #1 check(irq, 0);
    $display("event test done");
    wr(r_ctrl, 32'h0000_0001);
    wr(r_feat, 32'h0000_0080);
    cyc(1);
    rd(r_feat, 32'h0000_40C0);
    #1 check(irq, 1);
    wr(r_feat, 32'h0000_00C0);
    rd(r_feat, 32'h0000_4000);
    $display("user interrupt test done");
    tx_run <= 1;
    wr(r_feat, 32'h0000_1000);
    cyc(2);
    n0 = npoll;
    cyc(40);
    check(npoll - n0, 0);
    wr(r_ctrl, 32'h0000_0008);
    cyc(4);
    check(npoll - n0, 1);
    tx_run <= 0;
    wr(r_ctrl, 32'h0000_0008);
    cyc(20);
    check(npoll - n0, 1);
    tx_run <= 1;
    cyc(4);
    check(npoll - n0, 2);
    rx_done <= 1;
    cyc(1);
    rx_done <= 0;
    cyc(3);
    check(npoll - n0, 3);
    wr(r_feat, 32'h0000_0000);
    cyc(40);
    check(npoll - n0 > 4, 1);
    $display("poll test done");
    wr(r_feat, 32'h0000_0800);
    dis <= 1;
    for (k = 0; k < 8; k++) begin
      v = k < 2 ? 11'(59 + k) : 11'($random(seed) & 32'h0000_007F);
      cyc(1);
      len <= v;
      add <= k[0];
      cyc(2);
      #1 check(pad, v < 60 ? 32'(60 - v) : 0);
      check(fcs, v < 60 || k[0]);
    end
    cyc(1);
    add <= 1'b0;
    wr(r_feat, 32'h0000_0400);
    cyc(2);
    #1 check(strip, 1);
    check(fcs, 0);
    $display("pad and strip test done");
    end_of_test;
  end
endmodule // tfc_feature_ctrl_test
